/* gdf_pkg.sv */
/*
  Package for the gate driver fault status block: register offsets, status bit
  positions, reset values and the structs that carry grouped signals.
  Assumes a single 50 MHz clock domain and no other package.
*/
package gdf_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;

  // Register offsets.
  localparam logic [ADDR_W-1:0] FAULT_STATUS_OFFS = 7'h01;
  localparam logic [ADDR_W-1:0] PIN_READBACK_OFFS = 7'h04;

  // Status bit positions.
  localparam int unsigned PUMP_UV_BIT    = 3;
  localparam int unsigned A_SHORT_BIT    = 4;
  localparam int unsigned A_GROUND_BIT   = 5;
  localparam int unsigned A_SUPPLY_BIT   = 6;
  localparam int unsigned B_SHORT_BIT    = 8;
  localparam int unsigned B_GROUND_BIT   = 9;
  localparam int unsigned B_SUPPLY_BIT   = 10;
  localparam int unsigned C_SHORT_BIT    = 12;
  localparam int unsigned C_GROUND_BIT   = 13;
  localparam int unsigned C_SUPPLY_BIT   = 14;
  localparam int unsigned STATUS_W       = 15;

  // Implemented status bits; 0..2, 7 and 11 read as zero.
  localparam logic [STATUS_W-1:0] STATUS_IMPL_MASK = 15'h7778;
  // Ground and supply short flags hold the drive off.
  localparam logic [STATUS_W-1:0] STATUS_HOLD_MASK = 15'h6660;

  // Pin readback bit positions.
  localparam int unsigned PIN_A_LOW_BIT  = 0;
  localparam int unsigned PIN_A_HIGH_BIT = 1;
  localparam int unsigned PIN_B_LOW_BIT  = 2;
  localparam int unsigned PIN_B_HIGH_BIT = 3;
  localparam int unsigned PIN_C_LOW_BIT  = 4;
  localparam int unsigned PIN_C_HIGH_BIT = 5;
  localparam int unsigned PIN_ENABLE_BIT = 6;
  localparam int unsigned PIN_W          = 7;

  // Reset values.
  localparam logic [STATUS_W-1:0] STATUS_RST = 15'h0000;
  localparam logic [DATA_W-1:0]   RDATA_RST  = 32'h0000_0000;

  // Fault events of one phase, each a one-cycle or level indication.
  typedef struct packed {
    logic short_trig;
    logic ground;
    logic supply;
  } gdf_phase_evt_t;

  // Gate control input pins of one phase.
  typedef struct packed {
    logic high_in;
    logic low_in;
  } gdf_phase_pins_t;

  // Register access request.
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gdf_reg_req_t;

endpackage

/* gdf_flag_latch.sv */
/*
  Bank of sticky flags with write-one-to-clear.
  Assumes set and clear pulses are synchronous to clk_sys_in.
*/
`timescale 1ns/100ps
module gdf_flag_latch #(
  parameter int unsigned WIDTH = 15
) (
  input  wire logic             clk_sys_in,  // System clock.
  input  wire logic             nrst_in,     // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] set_in,      // Set request per flag.
  input  wire logic [WIDTH-1:0] clr_in,      // Clear request per flag.
  output logic      [WIDTH-1:0] flags_out    // Latched flags.
);

  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;

  // A set arriving in the clearing cycle wins, so no event is lost.
  assign nxt_flags = set_in | (flags_ff & ~clr_in);

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_out = flags_ff;

endmodule

/* gdf_fault_status.sv */
/*
  Fault status and pin readback registers of a three-phase gate driver.
  Latches charge-pump undervoltage and per-phase short faults, drives the
  status pin and the gate drive enable, and answers register reads and writes.
  Assumes a register port already decoded from the serial interface, and fault
  detector and pin inputs that are synchronous to clk_sys_in.
*/
`timescale 1ns/100ps
// Function
// RULE_01: Drive is off while the pump undervoltage condition is present.
// RULE_02: Pump undervoltage flag latches and stays set after the condition ends.
// RULE_03: Status bit 4 sets and holds once phase A short counter triggers.
// RULE_04: Phase A ground short sets bit 5, drive off until cleared.
// RULE_05: Phase A supply short sets bit 6, drive off until cleared.
// RULE_06: Status bit 8 sets and holds once phase B short counter triggers.
// RULE_07: Phase B ground short sets bit 9, drive off until cleared.
// RULE_08: Phase B supply short sets bit 10, drive off until cleared.
// RULE_09: Status bit 12 sets and holds once phase C short counter triggers.
// RULE_10: Phase C ground short sets bit 13, drive off until cleared.
// RULE_11: Phase C supply short sets bit 14, drive off until cleared.
// RULE_12: Status pin is the OR of all latched undervoltage and short flags.
// RULE_13: Offset 0x04 reads live gate inputs in bits 0-5, enable in bit 6.
// RULE_14: Pump undervoltage flag sits at status bit 3, one means detected.
// RULE_15: Writing one clears a flag; drive returns only when no fault remains. Drive ignores the latched undervoltage and short counter flags.
// RULE_16: Unused status bits 7 and 11 read zero and ignore writes.
module gdf_fault_status (
  input  wire logic                     clk_sys_in,       // System clock, 50 MHz.
  input  wire logic                     nrst_in,          // Asynchronous reset, active low.
  input  wire logic                     pump_uv_in,       // Live pump undervoltage level.
  input  gdf_pkg::gdf_phase_evt_t       phase_a_evt_in,   // Phase A fault events.
  input  gdf_pkg::gdf_phase_evt_t       phase_b_evt_in,   // Phase B fault events.
  input  gdf_pkg::gdf_phase_evt_t       phase_c_evt_in,   // Phase C fault events.
  input  gdf_pkg::gdf_phase_pins_t      phase_a_pins_in,  // Phase A gate inputs.
  input  gdf_pkg::gdf_phase_pins_t      phase_b_pins_in,  // Phase B gate inputs.
  input  gdf_pkg::gdf_phase_pins_t      phase_c_pins_in,  // Phase C gate inputs.
  input  wire logic                     gate_enable_in,   // Driver enable pin.
  input  gdf_pkg::gdf_reg_req_t         reg_req_in,       // Register read/write request.
  output logic [gdf_pkg::DATA_W-1:0]    reg_rdata_out,    // Read data, registered.
  output logic                          reg_rvalid_out,   // Read data valid pulse.
  output logic                          reg_err_out,      // Unmapped access pulse.
  output logic                          status_pin_out,   // Any fault flag set.
  output logic                          drive_enable_out  // Gate drive allowed.
);
  import gdf_pkg::*;

  // Status bit set requests gathered from the detectors.
  logic [STATUS_W-1:0] set_vec;
  logic [STATUS_W-1:0] clr_vec;
  logic [STATUS_W-1:0] flags;

  assign set_vec[PUMP_UV_BIT]  = pump_uv_in;               // RULE_14
  assign set_vec[A_SHORT_BIT]  = phase_a_evt_in.short_trig; // RULE_03
  assign set_vec[A_GROUND_BIT] = phase_a_evt_in.ground;     // RULE_04
  assign set_vec[A_SUPPLY_BIT] = phase_a_evt_in.supply;     // RULE_05
  assign set_vec[B_SHORT_BIT]  = phase_b_evt_in.short_trig; // RULE_06
  assign set_vec[B_GROUND_BIT] = phase_b_evt_in.ground;     // RULE_07
  assign set_vec[B_SUPPLY_BIT] = phase_b_evt_in.supply;     // RULE_08
  assign set_vec[C_SHORT_BIT]  = phase_c_evt_in.short_trig; // RULE_09
  assign set_vec[C_GROUND_BIT] = phase_c_evt_in.ground;     // RULE_10
  assign set_vec[C_SUPPLY_BIT] = phase_c_evt_in.supply;     // RULE_11
  assign set_vec[2:0]          = 3'h0;
  assign set_vec[7]            = 1'b0;                      // RULE_16
  assign set_vec[11]           = 1'b0;                      // RULE_16

  // Address decode.
  wire hit_status = (reg_req_in.addr == FAULT_STATUS_OFFS);
  wire hit_pins   = (reg_req_in.addr == PIN_READBACK_OFFS);
  wire wr_status  = reg_req_in.wr && hit_status;
  wire rd_any     = reg_req_in.rd;
  wire access     = reg_req_in.rd || reg_req_in.wr;
  // The pin readback register is read only, so a write to it counts as unmapped.
  wire bad_access = access && !(hit_status || (hit_pins && !reg_req_in.wr));

  // Write one to clear; unimplemented positions are masked out.
  assign clr_vec = wr_status ? (reg_req_in.wdata[STATUS_W-1:0] & STATUS_IMPL_MASK)
                             : '0;                          // RULE_15 RULE_16

  // Latching keeps the undervoltage and short flags for software to read.
  gdf_flag_latch #(
    .WIDTH (STATUS_W)
  ) u_flags (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .set_in     (set_vec),
    .clr_in     (clr_vec),
    .flags_out  (flags)
  );                                                        // RULE_02

  // Live pin image.
  logic [PIN_W-1:0] pin_image;
  assign pin_image[PIN_A_LOW_BIT]  = phase_a_pins_in.low_in;  // RULE_13
  assign pin_image[PIN_A_HIGH_BIT] = phase_a_pins_in.high_in; // RULE_13
  assign pin_image[PIN_B_LOW_BIT]  = phase_b_pins_in.low_in;  // RULE_13
  assign pin_image[PIN_B_HIGH_BIT] = phase_b_pins_in.high_in; // RULE_13
  assign pin_image[PIN_C_LOW_BIT]  = phase_c_pins_in.low_in;  // RULE_13
  assign pin_image[PIN_C_HIGH_BIT] = phase_c_pins_in.high_in; // RULE_13
  assign pin_image[PIN_ENABLE_BIT] = gate_enable_in;          // RULE_13

  // Read mux; the implemented mask guarantees zeros in unused positions.
  wire [DATA_W-1:0] status_word = {{(DATA_W-STATUS_W){1'b0}},
                                   flags & STATUS_IMPL_MASK}; // RULE_16
  wire [DATA_W-1:0] pin_word    = {{(DATA_W-PIN_W){1'b0}}, pin_image};
  wire [DATA_W-1:0] nxt_rdata   = hit_status ? status_word :
                                  hit_pins   ? pin_word    : RDATA_RST;

  logic [DATA_W-1:0] rdata_ff;
  logic              rvalid_ff;
  logic              err_ff;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_ff  <= RDATA_RST;
      rvalid_ff <= 1'b0;
      err_ff    <= 1'b0;
    end else begin
      if (rd_any) begin
        rdata_ff <= nxt_rdata;
      end
      rvalid_ff <= rd_any;
      err_ff    <= bad_access;
    end
  end

  // Status pin and drive enable are registered so the pins never glitch.
  // The clearing write reaches the pins one cycle after the flag update.
  wire any_flag   = |(flags & STATUS_IMPL_MASK);            // RULE_12
  wire hold_fault = |(flags & STATUS_HOLD_MASK);            // RULE_04 RULE_07 RULE_10
  // Drive stays off while undervoltage is present, independent of its flag.
  wire nxt_drive  = gate_enable_in && !pump_uv_in && !hold_fault; // RULE_01 RULE_15

  logic status_ff;
  logic drive_ff;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_ff <= 1'b0;
      drive_ff  <= 1'b0;
    end else begin
      status_ff <= any_flag;                                // RULE_12
      drive_ff  <= nxt_drive;                               // RULE_05 RULE_08 RULE_11
    end
  end

  assign reg_rdata_out    = rdata_ff;
  assign reg_rvalid_out   = rvalid_ff;
  assign reg_err_out      = err_ff;
  assign status_pin_out   = status_ff;
  assign drive_enable_out = drive_ff;

endmodule

/* gdf_host_model.sv */
/*
  Host model that issues register reads and writes to the fault status block.
  Assumes requests are taken at a rising edge and answered one cycle later.
*/
`timescale 1ns/100ps
module gdf_host_model import gdf_pkg::*; (
  input  wire logic              clk_sys_in, // System clock.
  output gdf_reg_req_t           req_out,    // Register request.
  input  wire logic [DATA_W-1:0] rdata_in,   // Read data.
  input  wire logic              rvalid_in,  // Read valid.
  input  wire logic              err_in      // Access error.
);
  initial req_out = '0;
  // Released address and data lines carry the inverse so stale values never pass.
  task automatic xfer(input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output logic v, output logic e);
    @(negedge clk_sys_in);
    req_out = '{rd: r, wr: !r, addr: a, wdata: d};
    @(negedge clk_sys_in);
    q = rdata_in;
    v = rvalid_in;
    e = err_in;
    req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

/* gdf_fault_status_props.sv */
/*
  Port checker for the fault status block.
  Assumes it is bound to gdf_fault_status and sees only its ports.
*/
`timescale 1ns/100ps
module gdf_fault_status_props import gdf_pkg::*; (
  input wire logic clk_sys_in, nrst_in, pump_uv_in, gate_enable_in,
  input gdf_phase_evt_t phase_a_evt_in, phase_b_evt_in, phase_c_evt_in,
  input gdf_phase_pins_t phase_a_pins_in, phase_b_pins_in, phase_c_pins_in,
  input gdf_reg_req_t reg_req_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic reg_rvalid_out, reg_err_out, status_pin_out, drive_enable_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  wire a_st = reg_req_in.addr == FAULT_STATUS_OFFS;
  wire a_pin = reg_req_in.addr == PIN_READBACK_OFFS;
  wire rd_st = reg_req_in.rd && a_st;
  wire bad = ((reg_req_in.rd || reg_req_in.wr) && !a_st && !a_pin) || (reg_req_in.wr && a_pin);
  wire hold_ev = |{phase_a_evt_in[1:0], phase_b_evt_in[1:0], phase_c_evt_in[1:0]};
  wire any_ev = hold_ev || pump_uv_in || phase_a_evt_in[2] || phase_b_evt_in[2]
                || phase_c_evt_in[2];
  property p_rvalid;
    reg_req_in.rd && (a_st || a_pin) |=> reg_rvalid_out && !reg_err_out;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  // A read of an unmapped address is still answered with valid, alongside the error.
  property p_err;
    bad |=> reg_err_out && (reg_rvalid_out == $past(reg_req_in.rd));
  endproperty
  a_err: assert property (p_err) else $error("bad access not flagged");
  property p_pins; reg_req_in.rd && a_pin |=> reg_rdata_out == {25'h0, $past(gate_enable_in),
    $past(phase_c_pins_in), $past(phase_b_pins_in), $past(phase_a_pins_in)}; endproperty
  a_pins: assert property (p_pins) else $error("pin readback wrong");
  property p_unused; rd_st |=> (reg_rdata_out & ~32'h0000_7778) == 32'h0; endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");
  property p_uv_drv; pump_uv_in |=> !drive_enable_out; endproperty
  a_uv_drv: assert property (p_uv_drv) else $error("drive on in undervoltage");
  property p_hold; hold_ev |-> ##2 !drive_enable_out; endproperty
  a_hold: assert property (p_hold) else $error("drive on after short");
  property p_stat; any_ev |-> ##2 status_pin_out; endproperty
  a_stat: assert property (p_stat) else $error("status pin not raised");
  property p_uv_flag; pump_uv_in ##2 rd_st |=> reg_rdata_out[3]; endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("pump flag not latched");
  property p_short; phase_a_evt_in.short_trig ##2 rd_st |=> reg_rdata_out[4]; endproperty
  a_short: assert property (p_short) else $error("short counter flag lost");
  property p_hold_rd; !reg_req_in.rd |=> $stable(reg_rdata_out); endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("read data moved");
endmodule
bind gdf_fault_status gdf_fault_status_props i_gdf_fault_status_props (.clk_sys_in, .nrst_in,
  .pump_uv_in, .gate_enable_in, .phase_a_evt_in, .phase_b_evt_in, .phase_c_evt_in,
  .phase_a_pins_in, .phase_b_pins_in, .phase_c_pins_in, .reg_req_in, .reg_rdata_out,
  .reg_rvalid_out, .reg_err_out, .status_pin_out, .drive_enable_out);

/* tb_top.sv */
/*
  Self-checking bench for the fault status block with a host model.
  Assumes the host model samples each transfer's answer half a cycle after the take edge.
*/
`timescale 1ns/100ps
module tb_top;
  import gdf_pkg::*;
  logic clk_sys_in, nrst_in, gate_enable_in, rvalid, err, stat, drv, v, e, r;
  logic [14:0] ev;
  logic [5:0]  pins;
  logic [6:0]  a;
  logic [31:0] rdata, q, seed;
  gdf_reg_req_t req;
  int n_mismatch, compares;
  int bits[10] = '{3, 4, 5, 6, 8, 9, 10, 12, 13, 14};
  gdf_fault_status i_gdf_fault_status (.clk_sys_in, .nrst_in, .pump_uv_in(ev[3]),
    .phase_a_evt_in(gdf_phase_evt_t'({ev[4], ev[5], ev[6]})),
    .phase_b_evt_in(gdf_phase_evt_t'({ev[8], ev[9], ev[10]})),
    .phase_c_evt_in(gdf_phase_evt_t'({ev[12], ev[13], ev[14]})),
    .phase_a_pins_in(gdf_phase_pins_t'(pins[1:0])),
    .phase_b_pins_in(gdf_phase_pins_t'(pins[3:2])),
    .phase_c_pins_in(gdf_phase_pins_t'(pins[5:4])), .gate_enable_in, .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .reg_err_out(err), .status_pin_out(stat),
    .drive_enable_out(drv));
  gdf_host_model i_gdf_host_model (.clk_sys_in, .req_out(req), .rdata_in(rdata),
    .rvalid_in(rvalid), .err_in(err));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic held(input int k);
    return k inside {5, 6, 9, 10, 13, 14};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xf(input logic r, input logic [6:0] ad, input logic [31:0] d);
    i_gdf_host_model.xfer(r, ad, d, q, v, e);
  endtask
  task automatic end_of_test;
    $display("compares %0d, n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    $display("BAD %0t timeout", $time);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    nrst_in = 1'b0; gate_enable_in = 1'b1; ev = '0; pins = '0; seed = 32'h0000_B4B6;
    repeat (2) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    xf(1'b1, FAULT_STATUS_OFFS, 32'h0);
    chk(q, 32'h0);
    chk(32'(drv), 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed); pins = seed[5:0]; gate_enable_in = seed[6];
      xf(1'b1, PIN_READBACK_OFFS, 32'h0);
      chk(q, {25'h0, gate_enable_in, pins});
    end
    gate_enable_in = 1'b1;
    $display("test pins done");
    foreach (bits[i]) begin
      @(negedge clk_sys_in) ev[bits[i]] = 1'b1;
      @(negedge clk_sys_in) ev = '0;
      xf(1'b1, FAULT_STATUS_OFFS, 32'h0);
      chk(q, 32'h1 << bits[i]);
      chk(32'(stat), 32'h1);
      chk(32'(drv), 32'(!held(bits[i])));
      seed = xs(seed);
      xf(1'b0, FAULT_STATUS_OFFS, (32'h1 << bits[i]) | (seed & 32'h0000_0887));
      xf(1'b1, FAULT_STATUS_OFFS, 32'h0);
      chk(q, 32'h0);
      chk(32'(drv), 32'h1);
      chk(32'(stat), 32'h0);
    end
    $display("test flags done");
    @(negedge clk_sys_in) begin ev[5] = 1'b1; ev[14] = 1'b1; end
    @(negedge clk_sys_in) ev = '0;
    xf(1'b0, FAULT_STATUS_OFFS, 32'h0000_0020);
    xf(1'b1, FAULT_STATUS_OFFS, 32'h0);
    chk(q, 32'h0000_4000);
    chk(32'(drv), 32'h0);
    xf(1'b0, FAULT_STATUS_OFFS, 32'h0000_4000);
    xf(1'b1, FAULT_STATUS_OFFS, 32'h0);
    chk(q, 32'h0);
    chk(32'(drv), 32'h1);
    chk(32'(stat), 32'h0);
    // A held undervoltage level must keep the drive off while it lasts.
    @(negedge clk_sys_in) ev[3] = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk(32'(drv), 32'h0);
    ev = '0;
    xf(1'b0, FAULT_STATUS_OFFS, 32'h0000_0008);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed); a = seed[6:0];
      if (a == 7'h01 || a == 7'h04) a ^= 7'h10;
      r = (i == 0) ? 1'b0 : seed[7];
      xf(r, (i == 0) ? PIN_READBACK_OFFS : a, seed);
      chk(32'(e), 32'h1);
      chk(32'(v), 32'(r));
    end
    xf(1'b1, FAULT_STATUS_OFFS, 32'h0);
    chk(q, 32'h0);
    chk(32'(drv), 32'h1);
    $display("test errors done");
    end_of_test();
  end
endmodule
